//--- hdl/icgw_pkg.sv
// Constants and carrier types for the indexed configuration unit.
// Assumes a single 40 MHz clock and a host that issues one I/O cycle at a time.
`default_nettype none

package icgw_pkg;
	// ----------------------------------------------------------------
	// Host port map
	// ----------------------------------------------------------------
	localparam logic [15:0] ICGW_INDEX_ADDR_LO = 16'h002E;
	localparam logic [15:0] ICGW_DATA_ADDR_LO  = 16'h002F;
	localparam logic [15:0] ICGW_INDEX_ADDR_HI = 16'h004E;
	localparam logic [15:0] ICGW_DATA_ADDR_HI  = 16'h004F;

	// ----------------------------------------------------------------
	// Keys
	// ----------------------------------------------------------------
	localparam logic [7:0] ICGW_ENTER_KEY = 8'h87;
	localparam logic [7:0] ICGW_EXIT_KEY  = 8'hAA;

	// ----------------------------------------------------------------
	// Configuration indices and logical device numbers
	// ----------------------------------------------------------------
	localparam logic [7:0] ICGW_IDX_DEVSEL   = 8'h07;
	localparam logic [7:0] ICGW_IDX_ACTIVATE = 8'h30;
	localparam logic [7:0] ICGW_IDX_DIR      = 8'hF0;
	localparam logic [7:0] ICGW_IDX_PINVAL   = 8'hF1;
	localparam logic [7:0] ICGW_IDX_INVERT   = 8'hF2;
	localparam logic [7:0] ICGW_IDX_WD_UNIT  = 8'hF5;
	localparam logic [7:0] ICGW_IDX_WD_COUNT = 8'hF6;
	localparam logic [7:0] ICGW_LDN_GPIO     = 8'h07;
	localparam logic [7:0] ICGW_LDN_WDOG     = 8'h08;

	// ----------------------------------------------------------------
	// Reset values and the one-second unit code
	// ----------------------------------------------------------------
	localparam logic [7:0] ICGW_DIR_RST    = 8'hFF;
	localparam logic [7:0] ICGW_PINVAL_RST = 8'h00;
	localparam logic [7:0] ICGW_INVERT_RST = 8'h00;
	localparam logic [7:0] ICGW_UNIT_SEC   = 8'h00;
	localparam logic [7:0] ICGW_UNIT_RST   = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int ICGW_CLK_HZ        = 40000000;
	localparam int ICGW_SEC_MS        = 1000;
	localparam int ICGW_MIN_MS        = 60000;
	localparam int ICGW_SEC_CYCLES    = ICGW_CLK_HZ / 1000 * ICGW_SEC_MS;
	// One minute of cycles overflows a signed 32-bit int
	localparam longint ICGW_MIN_CYCLES = longint'(ICGW_CLK_HZ / 1000) * ICGW_MIN_MS;
	localparam int ICGW_PULSE_CYCLES  = 16;

	// ----------------------------------------------------------------
	// Carrier of one host I/O cycle
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} icgw_io_t;

	typedef enum logic [2:0] {
		ICGW_LOCKED = 3'b001,
		ICGW_KEY1   = 3'b010,
		ICGW_OPEN   = 3'b100
	} icgw_mode_t;
endpackage : icgw_pkg

`default_nettype wire

//--- hdl/icgw_top.sv
// Keyed index/data configuration unit with an 8-bit port and watchdog.
// Assumes HOST_IO strobes are one-cycle pulses on REF_CLK; pins are async.
`default_nettype none

// Contract
// RULE1: Two consecutive enter-key writes to index port open configuration mode.
// RULE2: Exit-key write to index port closes configuration mode.
// RULE3: Index port is write-only, decoded at selectable low or high address.
// RULE4: Data port reads/writes the currently indexed register at paired address.
// RULE5: Index 07 then data selects the logical device for later indices.
// RULE6: Port direction, value and invert registers live in device 7.
// RULE7: Direction bit one means input, zero output; resets to all ones.
// RULE8: Output bits of value register are writable and readable; reset zero.
// RULE9: Input bits read pin state and ignore host writes.
// RULE10: Invert bit flips pin value both directions; resets to zero.
// RULE11: Watchdog configuration registers live in device 8.
// RULE12: Writing one to index 30 activates watchdog; zero deactivates it.
// RULE13: Writing zero to index F5 selects one-second count unit.
// RULE14: Expiry while active raises reset pulse or interrupt pulse.
// RULE15: After reset, configuration closed and watchdog inactive.
// RULE16: Loadable down-counter decrements per unit; rewrite restarts timing.
module icgw_top #(
	parameter int SEC_CYCLES   = icgw_pkg::ICGW_SEC_CYCLES,
	parameter longint MIN_CYCLES = icgw_pkg::ICGW_MIN_CYCLES,
	parameter int PULSE_CYCLES = icgw_pkg::ICGW_PULSE_CYCLES
) (
	input  wire logic            REF_CLK,
	input  wire logic            RST,
	input  wire logic            ADDR_SEL_HI,
	input  wire icgw_pkg::icgw_io_t HOST_IO,
	output var  logic [7:0]      HOST_RDATA,
	output var  logic            HOST_RVALID,
	input  wire logic [7:0]      GENERAL_PORT_BITS_IN,
	output var  logic [7:0]      GENERAL_PORT_BITS_OUT,
	output var  logic [7:0]      GENERAL_PORT_BITS_OE,
	output var  logic            WDOG_RESET,
	output var  logic            WDOG_IRQ,
	output var  logic            CFG_OPEN
);
	import icgw_pkg::*;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	icgw_mode_t  mode_ff;
	icgw_mode_t  nxt_mode;
	logic [7:0]  index_ff;
	logic [7:0]  ldn_ff;
	logic [7:0]  dir_ff;
	logic [7:0]  outval_ff;
	logic [7:0]  invert_ff;
	logic        wd_active_ff;
	logic [7:0]  wd_unit_ff;
	logic [7:0]  wd_count_ff;
	logic        wd_irq_mode_ff;
	logic [31:0] tick_cnt_ff;
	logic [5:0]  pulse_cnt_ff;
	logic [7:0]  pin_meta_ff;
	logic [7:0]  pin_sync_ff;
	logic        sel_meta_ff;
	logic        sel_sync_ff;

	logic [15:0] idx_addr;
	logic [15:0] dat_addr;
	logic        idx_wr;
	logic        dat_wr;
	logic        dat_rd;
	logic        cfg_wr;
	logic        unit_tick;
	logic        expire;
	logic [7:0]  pin_view;

	function automatic logic reg_hit(input logic [7:0] ldn, input logic [7:0] idx,
			input logic [7:0] want_ldn, input logic [7:0] want_idx);
		reg_hit = (ldn == want_ldn) && (idx == want_idx);
	endfunction : reg_hit

	// Address choice is a strap; sync it like any pin
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			sel_meta_ff <= 1'b0;
			sel_sync_ff <= 1'b0;
		end else begin
			sel_meta_ff <= ADDR_SEL_HI;
			sel_sync_ff <= sel_meta_ff;
		end
	end

	assign idx_addr = sel_sync_ff ? ICGW_INDEX_ADDR_HI : ICGW_INDEX_ADDR_LO; // RULE3
	assign dat_addr = sel_sync_ff ? ICGW_DATA_ADDR_HI : ICGW_DATA_ADDR_LO;   // RULE4
	assign idx_wr   = HOST_IO.wr && (HOST_IO.addr == idx_addr);
	assign dat_wr   = HOST_IO.wr && (HOST_IO.addr == dat_addr) && (mode_ff == ICGW_OPEN);
	assign dat_rd   = HOST_IO.rd && (HOST_IO.addr == dat_addr) && (mode_ff == ICGW_OPEN);
	assign cfg_wr   = dat_wr;

	// ----------------------------------------------------------------
	// Key sequencer
	// ----------------------------------------------------------------
	// Any other index-port write between the two keys restarts the sequence
	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			ICGW_LOCKED: begin
				if (idx_wr && HOST_IO.wdata == ICGW_ENTER_KEY) begin
					nxt_mode = ICGW_KEY1; // RULE1
				end
			end
			ICGW_KEY1: begin
				if (idx_wr) begin
					nxt_mode = (HOST_IO.wdata == ICGW_ENTER_KEY) ? ICGW_OPEN : ICGW_LOCKED; // RULE1
				end
			end
			ICGW_OPEN: begin
				if (idx_wr && HOST_IO.wdata == ICGW_EXIT_KEY) begin
					nxt_mode = ICGW_LOCKED; // RULE2
				end
			end
			default: begin
				nxt_mode = ICGW_LOCKED;
			end
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			mode_ff <= ICGW_LOCKED; // RULE15
		end else begin
			mode_ff <= nxt_mode;
		end
	end

	// Index latched only while open and never from the exit key, so the opening keys never become an index
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			index_ff <= 8'h00;
		end else if (idx_wr && mode_ff == ICGW_OPEN && HOST_IO.wdata != ICGW_EXIT_KEY) begin
			index_ff <= HOST_IO.wdata; // RULE3
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ldn_ff <= 8'h00;
		end else if (cfg_wr && index_ff == ICGW_IDX_DEVSEL) begin
			ldn_ff <= HOST_IO.wdata; // RULE5
		end
	end

	// ----------------------------------------------------------------
	// General-purpose port, device 7
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			pin_meta_ff <= 8'h00;
			pin_sync_ff <= 8'h00;
		end else begin
			pin_meta_ff <= GENERAL_PORT_BITS_IN;
			pin_sync_ff <= pin_meta_ff;
		end
	end

	assign pin_view = pin_sync_ff ^ invert_ff; // RULE10

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			dir_ff    <= ICGW_DIR_RST;    // RULE7
			invert_ff <= ICGW_INVERT_RST; // RULE10
		end else if (cfg_wr) begin
			if (reg_hit(ldn_ff, index_ff, ICGW_LDN_GPIO, ICGW_IDX_DIR)) begin
				dir_ff <= HOST_IO.wdata; // RULE6
			end else if (reg_hit(ldn_ff, index_ff, ICGW_LDN_GPIO, ICGW_IDX_INVERT)) begin
				invert_ff <= HOST_IO.wdata;
			end
		end
	end

	// Input bits keep their old latch; only output-direction bits take writes
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			outval_ff <= ICGW_PINVAL_RST; // RULE8
		end else if (cfg_wr && reg_hit(ldn_ff, index_ff, ICGW_LDN_GPIO, ICGW_IDX_PINVAL)) begin
			outval_ff <= (HOST_IO.wdata & ~dir_ff) | (outval_ff & dir_ff); // RULE9
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			GENERAL_PORT_BITS_OUT <= 8'h00;
			GENERAL_PORT_BITS_OE  <= 8'h00;
		end else begin
			GENERAL_PORT_BITS_OUT <= outval_ff ^ invert_ff; // RULE10
			GENERAL_PORT_BITS_OE  <= ~dir_ff;               // RULE7
		end
	end

	// ----------------------------------------------------------------
	// Watchdog, device 8
	// ----------------------------------------------------------------
	// Unit register bit 3 picks interrupt instead of reset on expiry
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			wd_active_ff   <= 1'b0; // RULE15
			wd_unit_ff     <= ICGW_UNIT_RST;
			wd_irq_mode_ff <= 1'b0;
		end else if (cfg_wr) begin
			if (reg_hit(ldn_ff, index_ff, ICGW_LDN_WDOG, ICGW_IDX_ACTIVATE)) begin
				wd_active_ff <= HOST_IO.wdata[0]; // RULE12
			end else if (reg_hit(ldn_ff, index_ff, ICGW_LDN_WDOG, ICGW_IDX_WD_UNIT)) begin
				wd_unit_ff     <= HOST_IO.wdata; // RULE13
				wd_irq_mode_ff <= HOST_IO.wdata[3];
			end
		end
	end

	logic count_wr;
	assign count_wr = cfg_wr && reg_hit(ldn_ff, index_ff, ICGW_LDN_WDOG, ICGW_IDX_WD_COUNT); // RULE11

	// Prescaler restarts on count write so the first unit is a full one
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			tick_cnt_ff <= 32'h00000000;
		end else if (count_wr || !wd_active_ff || unit_tick) begin
			tick_cnt_ff <= 32'h00000000; // RULE16
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
		end
	end

	assign unit_tick = (wd_unit_ff == ICGW_UNIT_SEC)
		? (tick_cnt_ff == 32'(SEC_CYCLES - 1))
		: (tick_cnt_ff == 32'(MIN_CYCLES - 1)); // RULE13

	assign expire = wd_active_ff && unit_tick && (wd_count_ff == 8'h01);

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			wd_count_ff <= 8'h00;
		end else if (count_wr) begin
			wd_count_ff <= HOST_IO.wdata; // RULE16
		end else if (wd_active_ff && unit_tick && wd_count_ff != 8'h00) begin
			wd_count_ff <= wd_count_ff - 8'h01; // RULE16
		end
	end

	// Stretched so a slow reset controller still sees it
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			pulse_cnt_ff <= 6'h00;
			WDOG_RESET   <= 1'b0;
			WDOG_IRQ     <= 1'b0;
		end else if (expire) begin
			pulse_cnt_ff <= 6'(PULSE_CYCLES - 1);
			WDOG_RESET   <= !wd_irq_mode_ff; // RULE14
			WDOG_IRQ     <= wd_irq_mode_ff;  // RULE14
		end else if (pulse_cnt_ff != 6'h00) begin
			pulse_cnt_ff <= pulse_cnt_ff - 6'h01;
		end else begin
			WDOG_RESET <= 1'b0;
			WDOG_IRQ   <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			HOST_RDATA  <= 8'h00;
			HOST_RVALID <= 1'b0;
			CFG_OPEN    <= 1'b0;
		end else begin
			HOST_RVALID <= dat_rd; // RULE4
			CFG_OPEN    <= (nxt_mode == ICGW_OPEN);
			if (dat_rd) begin
				if (index_ff == ICGW_IDX_DEVSEL) begin
					HOST_RDATA <= ldn_ff;
				end else if (reg_hit(ldn_ff, index_ff, ICGW_LDN_GPIO, ICGW_IDX_DIR)) begin
					HOST_RDATA <= dir_ff;
				end else if (reg_hit(ldn_ff, index_ff, ICGW_LDN_GPIO, ICGW_IDX_PINVAL)) begin
					HOST_RDATA <= (outval_ff & ~dir_ff) | (pin_view & dir_ff); // RULE9
				end else if (reg_hit(ldn_ff, index_ff, ICGW_LDN_GPIO, ICGW_IDX_INVERT)) begin
					HOST_RDATA <= invert_ff;
				end else if (reg_hit(ldn_ff, index_ff, ICGW_LDN_WDOG, ICGW_IDX_ACTIVATE)) begin
					HOST_RDATA <= {7'h00, wd_active_ff};
				end else if (reg_hit(ldn_ff, index_ff, ICGW_LDN_WDOG, ICGW_IDX_WD_UNIT)) begin
					HOST_RDATA <= wd_unit_ff;
				end else if (reg_hit(ldn_ff, index_ff, ICGW_LDN_WDOG, ICGW_IDX_WD_COUNT)) begin
					HOST_RDATA <= wd_count_ff;
				end else begin
					HOST_RDATA <= 8'h00;
				end
			end
		end
	end
endmodule : icgw_top

`default_nettype wire

//--- sim/icgw_chk.sv
// Checker for the configuration unit, watching only the top ports.
// Assumes one clock domain; bound to every instance of the top module.
`default_nettype none

module icgw_chk #(
	parameter int SEC_CYCLES   = 10,
	parameter longint MIN_CYCLES = 20,
	parameter int PULSE_CYCLES = 16
) (
	input wire logic               REF_CLK,
	input wire logic               RST,
	input wire logic               ADDR_SEL_HI,
	input wire icgw_pkg::icgw_io_t HOST_IO,
	input wire logic [7:0]         HOST_RDATA,
	input wire logic               HOST_RVALID,
	input wire logic [7:0]         GENERAL_PORT_BITS_IN,
	input wire logic [7:0]         GENERAL_PORT_BITS_OUT,
	input wire logic [7:0]         GENERAL_PORT_BITS_OE,
	input wire logic               WDOG_RESET,
	input wire logic               WDOG_IRQ,
	input wire logic               CFG_OPEN
);
	timeunit 1ns;
	timeprecision 100ps;
	import icgw_pkg::*;
	logic [31:0] hi_cnt_ff;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);

	// --------------------------------
	// Pulse width count
	// --------------------------------
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST)
			hi_cnt_ff <= 32'h0;
		else
			hi_cnt_ff <= WDOG_RESET ? hi_cnt_ff + 32'h1 : 32'h0;
	end

	rd_cause_a: assert property (HOST_RVALID |-> $past(HOST_IO.rd && CFG_OPEN))
		else $error("read answer without an open read");
	rdata_hold_a: assert property (!HOST_RVALID |-> $stable(HOST_RDATA))
		else $error("read data moved without answer");
	lock_rd_a: assert property (!CFG_OPEN && HOST_IO.rd |=> !HOST_RVALID)
		else $error("read answered while closed");
	idx_rd_a: assert property (HOST_IO.rd && (HOST_IO.addr == ICGW_INDEX_ADDR_LO
		|| HOST_IO.addr == ICGW_INDEX_ADDR_HI) |=> !HOST_RVALID)
		else $error("index port answered a read");
	open_key_a: assert property ($rose(CFG_OPEN)
		|-> $past(HOST_IO.wr && HOST_IO.wdata == ICGW_ENTER_KEY))
		else $error("opened without key write");
	exit_close_a: assert property (CFG_OPEN && HOST_IO.wr && HOST_IO.wdata == ICGW_EXIT_KEY
		&& HOST_IO.addr == ICGW_INDEX_ADDR_LO |=> !CFG_OPEN)
		else $error("exit key did not close");
	oe_cause_a: assert property ($changed(GENERAL_PORT_BITS_OE)
		|-> $past(HOST_IO.wr && CFG_OPEN, 2))
		else $error("drive enable moved without write");
	pulse_len_a: assert property ($fell(WDOG_RESET) |-> hi_cnt_ff == 32'(PULSE_CYCLES))
		else $error("reset pulse width wrong");
	reset_state_a: assert property ($fell(RST) |-> !CFG_OPEN && !WDOG_RESET && !WDOG_IRQ)
		else $error("state after reset wrong");
endmodule : icgw_chk

bind icgw_top icgw_chk #(.SEC_CYCLES(SEC_CYCLES), .MIN_CYCLES(MIN_CYCLES),
	.PULSE_CYCLES(PULSE_CYCLES)) icgw_chk_i (.REF_CLK(REF_CLK), .RST(RST),
	.ADDR_SEL_HI(ADDR_SEL_HI), .HOST_IO(HOST_IO), .HOST_RDATA(HOST_RDATA),
	.HOST_RVALID(HOST_RVALID), .GENERAL_PORT_BITS_IN(GENERAL_PORT_BITS_IN),
	.GENERAL_PORT_BITS_OUT(GENERAL_PORT_BITS_OUT), .GENERAL_PORT_BITS_OE(GENERAL_PORT_BITS_OE),
	.WDOG_RESET(WDOG_RESET), .WDOG_IRQ(WDOG_IRQ), .CFG_OPEN(CFG_OPEN));

`default_nettype wire

//--- sim/icgw_host.sv
// Host processor model issuing single I/O cycles.
// Assumes callers run on the falling edge of the bus clock.
`default_nettype none

module icgw_host (
	input  wire logic               clk,
	output var  icgw_pkg::icgw_io_t io
);
	timeunit 1ns;
	timeprecision 100ps;
	import icgw_pkg::*;

	initial io = '0;

	task automatic acc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		io = {w, r, a, d};
	endtask : acc

	// Released bus shows the inverse, so stale values never decode
	task automatic idle();
		@(negedge clk);
		io = {1'b0, 1'b0, ~io.addr, ~io.wdata};
	endtask : idle
endmodule : icgw_host

`default_nettype wire

//--- sim/tb.sv
// Self-checking bench for the configuration unit.
// Assumes the host model drives every I/O cycle on the falling edge.
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import icgw_pkg::*;
	logic        clk, rst, sel, rvalid, wrst, wirq, open;
	icgw_io_t    io;
	logic [7:0]  rdata, pin_in, pout, poe, d, iv, v, p;
	logic [15:0] base;
	logic [7:0]  exp_q[$];
	int          fail_count, tests_run;

	icgw_top #(.SEC_CYCLES(10), .MIN_CYCLES(20), .PULSE_CYCLES(4)) icgw_top_i (
		.REF_CLK(clk), .RST(rst), .ADDR_SEL_HI(sel), .HOST_IO(io), .HOST_RDATA(rdata),
		.HOST_RVALID(rvalid), .GENERAL_PORT_BITS_IN(pin_in), .GENERAL_PORT_BITS_OUT(pout),
		.GENERAL_PORT_BITS_OE(poe), .WDOG_RESET(wrst), .WDOG_IRQ(wirq), .CFG_OPEN(open));
	icgw_host icgw_host_i (.clk(clk), .io(io));

	// --------------------------------
	// Helpers
	// --------------------------------
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic chkb(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("[FAIL] %s exp %b got %b", n, e, g);
		end
	endtask : chkb
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask : w
	task automatic iw(input logic [7:0] x);
		icgw_host_i.acc(1'b1, 1'b0, base, x);
		icgw_host_i.idle();
	endtask : iw
	task automatic rg_wr(input logic [7:0] i, input logic [7:0] x);
		iw(i);
		icgw_host_i.acc(1'b1, 1'b0, base + 16'h0001, x);
		icgw_host_i.idle();
	endtask : rg_wr
	task automatic rg_rd(input logic [7:0] i, input logic [7:0] e);
		iw(i);
		exp_q.push_back(e);
		icgw_host_i.acc(1'b0, 1'b1, base + 16'h0001, 8'h00);
		icgw_host_i.idle();
	endtask : rg_rd
	// A read that must draw no answer
	task automatic nr(input logic [15:0] a);
		icgw_host_i.acc(1'b0, 1'b1, a, 8'h00);
		icgw_host_i.idle();
	endtask : nr
	task automatic keys();
		icgw_host_i.acc(1'b1, 1'b0, base, ICGW_ENTER_KEY);
		icgw_host_i.acc(1'b1, 1'b0, base, ICGW_ENTER_KEY);
		icgw_host_i.idle();
	endtask : keys
	task automatic wrap_up();
		if (fail_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(negedge clk) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) begin
				fail_count++;
				$display("[FAIL] rdata exp none got %h", rdata);
			end else
				chk("rdata", exp_q.pop_front(), rdata);
		end
	end

	initial begin
		repeat (4000) @(posedge clk);
		fail_count++;
		wrap_up();
	end

	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		rst = 1'b1;
		sel = 1'b0;
		fail_count = 0;
		tests_run = 0;
		base = ICGW_INDEX_ADDR_LO;
		void'($urandom(88));
		p = 8'($urandom);
		d = 8'($urandom);
		iv = 8'($urandom);
		v = 8'($urandom);
		pin_in = p;
		w(8);
		rst = 1'b0;
		chkb("cfg_open", 1'b0, open);
		nr(base + 16'h0001);
		icgw_host_i.acc(1'b1, 1'b0, base, ICGW_ENTER_KEY);
		iw(ICGW_IDX_DEVSEL);
		iw(ICGW_ENTER_KEY);
		chkb("cfg_open", 1'b0, open);
		keys();
		chkb("cfg_open", 1'b1, open);
		nr(base);
		rg_wr(ICGW_IDX_DEVSEL, ICGW_LDN_GPIO);
		rg_rd(ICGW_IDX_DIR, ICGW_DIR_RST);
		rg_rd(ICGW_IDX_INVERT, ICGW_INVERT_RST);
		rg_rd(ICGW_IDX_PINVAL, p);
		rg_wr(ICGW_IDX_DIR, d);
		rg_wr(ICGW_IDX_INVERT, iv);
		rg_wr(ICGW_IDX_PINVAL, v);
		w(2);
		chk("port_oe", ~d, poe);
		chk("port_out", (v ^ iv) & ~d, pout & poe);
		rg_rd(ICGW_IDX_PINVAL, (v & ~d) | ((p ^ iv) & d));
		rg_wr(ICGW_IDX_DEVSEL, ICGW_LDN_WDOG);
		rg_rd(ICGW_IDX_DIR, 8'h00);
		rg_wr(ICGW_IDX_ACTIVATE, 8'h01);
		rg_wr(ICGW_IDX_WD_UNIT, ICGW_UNIT_SEC);
		rg_wr(ICGW_IDX_WD_COUNT, 8'h03);
		w(15);
		rg_wr(ICGW_IDX_WD_COUNT, 8'h03);
		w(20);
		chkb("wdog_rst", 1'b0, wrst);
		for (int k = 0; k < 30 && wrst !== 1'b1; k++) w(1);
		chkb("wdog_rst", 1'b1, wrst);
		rg_wr(ICGW_IDX_ACTIVATE, 8'h00);
		rg_wr(ICGW_IDX_WD_COUNT, 8'h01);
		w(30);
		chkb("wdog_rst", 1'b0, wrst);
		rg_wr(ICGW_IDX_WD_UNIT, 8'h08);
		rg_wr(ICGW_IDX_ACTIVATE, 8'h01);
		for (int k = 0; k < 40 && wirq !== 1'b1; k++) w(1);
		chkb("wdog_irq", 1'b1, wirq);
		iw(ICGW_EXIT_KEY);
		chkb("cfg_open", 1'b0, open);
		nr(base + 16'h0001);
		sel = 1'b1;
		base = ICGW_INDEX_ADDR_HI;
		w(3);
		keys();
		chkb("cfg_open", 1'b1, open);
		rg_wr(ICGW_IDX_DEVSEL, ICGW_LDN_GPIO);
		rg_rd(ICGW_IDX_DIR, d);
		iw(ICGW_EXIT_KEY);
		w(4);
		chk("pending", 8'(exp_q.size()), 8'h00);
		wrap_up();
	end
endmodule : tb

`default_nettype wire
